// ==== bench/iam_host.sv ====
// Host model issuing additional status commands
`timescale 1ns/1ps
module iam_host (
    input  wire logic        clk,
    output logic             cmd_valid,
    output logic [7:0]       cmd_num,
    input  wire logic        rsp_valid_q,
    input  wire logic [19:0] rsp_status_q
);
    initial begin
        cmd_valid = 1'b0;
        cmd_num = 8'h00;
    end
    task automatic ask(input logic [7:0] num, output logic [19:0] st, output logic got);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_num <= num;
        @(posedge clk);
        cmd_valid <= 1'b0;
        // Released number flips so a stale value cannot pass
        cmd_num <= ~num;
        @(posedge clk);
        got = rsp_valid_q;
        st = rsp_status_q;
    endtask : ask
endmodule : iam_host

// ==== bench/iam_props.sv ====
// Port checker for the alert monitor
`timescale 1ns/1ps
module iam_props
    import iam_pkg::*;
(
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        sensor_invalid,
    input wire logic        cmd_valid,
    input wire logic [7:0]  cmd_num,
    input wire logic        rsp_valid_q,
    input wire logic [19:0] rsp_status_q,
    input wire logic [19:0] active_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // Internal reset lags the pin, so input latency is judged only once settled
    logic [2:0] up_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) up_q <= 3'h0;
        else if (up_q != 3'h7) up_q <= up_q + 3'h1;
    end
    wire logic cmd48 = cmd_valid && cmd_num == CMD_ADD_STAT;
    wire logic ok    = up_q == 3'h7;
    property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
    property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0000_0000; endproperty
    property p_rsp; cmd48 |=> rsp_valid_q && rsp_status_q == $past(active_q); endproperty
    property p_norsp; !cmd48 |=> !rsp_valid_q; endproperty
    property p_hw_fixed;
        wb_ack_o && !wb_we_i && wb_adr_i == REG_ENABLE |-> wb_dat_o[4:0] == 5'h1f;
    endproperty
    property p_flash; active_q[A_FLASH] |=> active_q[A_FLASH]; endproperty
    property p_cnvm; active_q[A_CNVM] |=> active_q[A_CNVM]; endproperty
    property p_sens_on; (ok && sensor_invalid) [*4] |-> active_q[A_SENSOR]; endproperty
    property p_sens_off; (ok && !sensor_invalid) [*4] |-> !active_q[A_SENSOR]; endproperty
    a_ack: assert property (p_ack) else $error("ack missing");
    a_ack_one: assert property (p_ack_one) else $error("ack too long");
    a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
    a_rsp: assert property (p_rsp) else $error("status reply wrong");
    a_norsp: assert property (p_norsp) else $error("reply without command");
    a_hw_fixed: assert property (p_hw_fixed) else $error("fixed enables lost");
    a_flash: assert property (p_flash) else $error("flash alert not held");
    a_cnvm: assert property (p_cnvm) else $error("store alert not held");
    a_sens_on: assert property (p_sens_on) else $error("sensor alert missing");
    a_sens_off: assert property (p_sens_off) else $error("sensor alert stuck");
    c_cmd: cover property (cmd48);
    c_wr: cover property (wb_ack_o && wb_we_i);
    c_sens: cover property (active_q[A_SENSOR]);
endmodule : iam_props

bind iam_monitor iam_props iam_props_i (.clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .sensor_invalid(sensor_invalid), .cmd_valid(cmd_valid),
    .cmd_num(cmd_num), .rsp_valid_q(rsp_valid_q), .rsp_status_q(rsp_status_q),
    .active_q(active_q));

// ==== bench/instrument_alert_monitor_tb.sv ====
// Self-checking bench of the alert monitor
`timescale 1ns/1ps
module instrument_alert_monitor_tb
    import iam_pkg::*;
;
    logic clk = 1'b0, resetn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
    logic pmode = 1'b0, pwl = 1'b0, cset = 1'b0, got, rsp_v, cmd_v;
    logic [7:0] adr = 8'h00, cmd_n;
    logic [31:0] wdat = 32'h0000_0000, rdat, q, lfsr_q = 32'hc115_4fad;
    logic [15:0] flt = 16'h0000;
    logic [9:0] pmeas = 10'h000, psetp = 10'h000, trav = 10'h000, drv = 10'h1f4;
    logic [19:0] act, rsp_s, st, exp;
    int err_count = 0, num_checks = 0, b, v;
    logic [31:0] rec_q[$];
    localparam logic [7:0] RA [4] = '{REG_CYC_PT, REG_DBAND, REG_PDEV, 8'h3c};
    localparam logic [31:0] RV [4] = '{CYC_PT_RST, DBAND_RST, PDEV_RST, 32'h0000_0000};
    localparam int AL [8] = '{A_SENSOR, A_DRVCUR, A_CAL, A_DIAG, A_AUTOCAL, A_DDATA,
                              A_SATHI, A_SATLO};
    localparam logic [9:0] TR [5] = '{10'h1f4, 10'h0c8, 10'h1f4, 10'h1c2, 10'h1f4};
    always #12.5 clk = ~clk;
    iam_monitor iam_monitor_i (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .flash_fault(flt[A_FLASH]), .drive_cur_fault(flt[A_DRVCUR]),
        .nonvolatile_store_fault(flt[A_CNVM]), .sensor_invalid(flt[A_SENSOR]),
        .loop_cur_gross(flt[A_LOOP]), .autocal_run(flt[A_AUTOCAL]), .cal_run(flt[A_CAL]),
        .diag_run(flt[A_DIAG]), .diag_data_held(flt[A_DDATA]), .integ_at_high(flt[A_SATHI]),
        .integ_at_low(flt[A_SATLO]), .pressure_mode(pmode), .pressure_meas(pmeas),
        .pressure_setp(psetp), .drive_sig(drv), .travel(trav), .power_was_lost(pwl),
        .clock_set(cset), .cmd_valid(cmd_v), .cmd_num(cmd_n), .rsp_valid_q(rsp_v),
        .rsp_status_q(rsp_s), .active_q(act));
    iam_host iam_host_i (.clk(clk), .cmd_valid(cmd_v), .cmd_num(cmd_n),
        .rsp_valid_q(rsp_v), .rsp_status_q(rsp_s));
    task automatic report_and_stop;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] expv);
        num_checks++;
        if (seen !== expv) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, expv, seen);
        end
    endtask : chk
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= ~w;
        adr <= ~a;
        wdat <= ~d;
        if (n >= 20) begin
            err_count++;
            report_and_stop();
        end
        @(posedge clk);
    endtask : wb
    // Record model: entries beyond the depth are dropped
    task automatic store(input logic [19:0] e);
        if (rec_q.size() < REC_DEPTH) rec_q.push_back(32'(e));
    endtask : store
    task automatic chk_stat;
        wb(1'b0, REG_REC_STAT, 32'h0);
        v = rec_q.size();
        chk("record status", q, 32'(v * 4 + (v == REC_DEPTH) * 2 + (v != 0)));
    endtask : chk_stat
    task automatic do_reset;
        resetn <= 1'b0;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        rec_q.delete();
    endtask : do_reset
    task automatic pulse_sensor;
        flt[A_SENSOR] <= 1'b1;
        repeat (5) @(posedge clk);
        flt[A_SENSOR] <= 1'b0;
        repeat (5) @(posedge clk);
        store(20'h0_0001 << A_SENSOR);
    endtask : pulse_sensor
    initial begin
        do_reset();
        wb(1'b1, REG_ENABLE, 32'h0000_0000);
        wb(1'b0, REG_ENABLE, 32'h0);
        chk("enable", q, 32'h0000_001f);
        for (int i = 0; i < 4; i++) begin
            wb(1'b0, RA[i], 32'h0);
            chk("reset value", q, RV[i]);
        end
        for (int i = 0; i < 8; i++) begin
            b = AL[i];
            exp = 20'h0_0001 << b;
            flt[b] <= 1'b1;
            repeat (5) @(posedge clk);
            chk("masked", act, (b < 5) ? exp : 20'h0_0000);
            wb(1'b1, REG_ENABLE, 32'(exp));
            repeat (2) @(posedge clk);
            chk("active", act, exp);
            iam_host_i.ask(CMD_ADD_STAT, st, got);
            chk("status reply", {got, st}, {1'b1, exp});
            store(exp);
            flt[b] <= 1'b0;
            repeat (5) @(posedge clk);
            chk("cleared", act, 20'h0_0000);
            wb(1'b1, REG_ENABLE, 32'h0000_0000);
        end
        iam_host_i.ask(8'h2f, st, got);
        chk("other command", got, 32'h0);
        for (int i = 0; i < 8; i++) begin
            wb(1'b0, REG_REC_BASE + 8'(4 * i), 32'h0);
            chk("record entry", q, rec_q[i]);
        end
        for (int i = 0; i < 15; i++) pulse_sensor();
        chk_stat();
        wb(1'b0, REG_REC_BASE + 8'h50, 32'h0);
        chk("entry beyond count", q, 32'h0000_0000);
        wb(1'b1, REG_REC_CTRL, 32'h0000_0001);
        rec_q.delete();
        chk_stat();
        pulse_sensor();
        chk_stat();
        // Cycle counter: two real reversals, then a wiggle inside the deadband
        wb(1'b1, REG_CYC_CNT, 32'h0000_0000);
        for (int i = 0; i < 5; i++) begin
            trav <= TR[i];
            repeat (6) @(posedge clk);
        end
        wb(1'b0, REG_CYC_CNT, 32'h0);
        chk("cycle count", q, 32'h0000_0002);
        wb(1'b1, REG_CYC_PT, 32'h0000_0001);
        wb(1'b1, REG_ENABLE, 32'h0000_0001 << A_CYCHI);
        repeat (2) @(posedge clk);
        chk("cycle high", act[A_CYCHI], 32'h1);
        wb(1'b1, REG_CYC_CNT, 32'h0000_0000);
        repeat (2) @(posedge clk);
        chk("cycle high cleared", act[A_CYCHI], 32'h0);
        lfsr_q = lfsr_next(lfsr_q);
        wb(1'b1, REG_CYC_CNT, lfsr_q & 32'h0000_ffff);
        wb(1'b0, REG_CYC_CNT, 32'h0);
        chk("cycle count write", q, lfsr_q & 32'h0000_ffff);
        wb(1'b1, REG_ENABLE, 32'h0000_0001 << A_PDEV);
        for (int k = 0; k < 3; k++) begin
            lfsr_q = lfsr_next(lfsr_q);
            v = (k == 1) ? int'(lfsr_q[15:0]) % 50 : 60;
            psetp <= 10'(100 + int'(lfsr_q[31:16]) % 800);
            pmeas <= 10'(100 + int'(lfsr_q[31:16]) % 800 + v);
            pmode <= (k != 2);
            repeat (5) @(posedge clk);
            chk("pressure deviation", act[A_PDEV], 32'(k == 0));
        end
        wb(1'b1, REG_ENABLE, 32'h0000_0001 << A_TIME);
        pwl <= 1'b1;
        repeat (3) @(posedge clk);
        pwl <= 1'b0;
        repeat (5) @(posedge clk);
        chk("time approximate", act[A_TIME], 32'h1);
        cset <= 1'b1;
        repeat (3) @(posedge clk);
        cset <= 1'b0;
        repeat (5) @(posedge clk);
        chk("time set", act[A_TIME], 32'h0);
        // Closed unpowered mismatch: far shorter than the alert delay, so no alert yet
        wb(1'b1, REG_ENABLE, 32'h0000_0001 << A_DRVSIG);
        drv <= 10'h000;
        repeat (50) @(posedge clk);
        chk("drive alert early", act[A_DRVSIG], 32'h0);
        drv <= 10'h1f4;
        wb(1'b1, REG_ENABLE, 32'h0000_0000);
        flt <= 16'h0015;
        repeat (5) @(posedge clk);
        flt <= 16'h0000;
        repeat (5) @(posedge clk);
        chk("latched faults", act, 32'h0000_0015);
        flt <= 16'h0001;
        do_reset();
        repeat (4) @(posedge clk);
        chk("after restart", act, 32'h0000_0001);
        report_and_stop();
    end
endmodule : instrument_alert_monitor_tb

// ==== core/iam_drive_check.sv ====
// Drive signal versus travel consistency timer
`timescale 1ns/1ps
module iam_drive_check
    import iam_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [9:0] drive,
    input  wire logic [9:0] travel,
    input  wire logic       open_unpowered,
    input  wire logic       enable,
    output logic            alert_q
);
    logic        mismatch;
    logic [31:0] cnt_q;

    always_comb begin
        if (open_unpowered) begin
            mismatch = (drive < PCT_10 && travel < PCT_97) ||
                       (drive > PCT_90 && travel > PCT_3);
        end else begin
            mismatch = (drive < PCT_10 && travel > PCT_3) ||
                       (drive > PCT_90 && travel < PCT_97);
        end
    end

    // Any break in the mismatch restarts the 20 s window
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q   <= 32'h0000_0000;
            alert_q <= 1'b0;
        end else if (!enable || !mismatch) begin
            cnt_q   <= 32'h0000_0000;
            alert_q <= 1'b0;
        end else if (cnt_q > DRV_CYC) begin
            alert_q <= 1'b1;
        end else begin
            cnt_q   <= cnt_q + 32'h0000_0001;
        end
    end
endmodule : iam_drive_check

// ==== core/iam_monitor.sv ====
// Instrument alert monitor: alert evaluation, alert record and status reply
`timescale 1ns/1ps
module iam_monitor
    import iam_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        flash_fault,
    input  wire logic        drive_cur_fault,
    input  wire logic        nonvolatile_store_fault,
    input  wire logic        sensor_invalid,
    input  wire logic        loop_cur_gross,
    input  wire logic        autocal_run,
    input  wire logic        cal_run,
    input  wire logic        diag_run,
    input  wire logic        diag_data_held,
    input  wire logic        integ_at_high,
    input  wire logic        integ_at_low,
    input  wire logic        pressure_mode,
    input  wire logic [9:0]  pressure_meas,
    input  wire logic [9:0]  pressure_setp,
    input  wire logic [9:0]  drive_sig,
    input  wire logic [9:0]  travel,
    input  wire logic        power_was_lost,
    input  wire logic        clock_set,
    input  wire logic        cmd_valid,
    input  wire logic [7:0]  cmd_num,
    output logic             rsp_valid_q,
    output logic [19:0]      rsp_status_q,
    output logic [19:0]      active_q
);
    import iam_pkg::*;

    logic        rst_s1_q, rst_n;
    logic [19:0] in_raw, in_s1_q, in_s2_q;
    logic [19:0] cond;
    logic [31:0] enable_q;
    logic [19:0] en_eff;
    logic [2:0]  latch_q;
    logic [19:0] prev_q;
    logic [19:0] rise;
    logic [19:0] rec_mem [REC_DEPTH];
    logic [4:0]  rec_cnt_q;
    logic        rec_full_q, rec_ne_q;
    logic        time_approx_q;
    logic [31:0] cyc_cnt_q, cyc_pt_q, dband_q, pdev_q;
    logic        open_unpowered_q;
    logic [9:0]  ref_q, ext_q;
    logic        dir_up_q;
    logic        drv_alert;
    logic        wb_req, wb_wr, clr_req;
    logic [9:0]  pdiff;
    logic [7:0]  rec_off;

    // Reset release
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    // Status pins come from other logic; two flops each
    assign in_raw = {integ_at_low, integ_at_high, diag_data_held, diag_run, cal_run,
                     autocal_run, loop_cur_gross, sensor_invalid, nonvolatile_store_fault,
                     drive_cur_fault, flash_fault, pressure_mode, power_was_lost,
                     clock_set, 6'h00};
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            in_s1_q <= 20'h0_0000;
            in_s2_q <= 20'h0_0000;
        end else begin
            in_s1_q <= in_raw;
            in_s2_q <= in_s1_q;
        end
    end

    assign wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr   = wb_req && wb_we_i && (&wb_sel_i);
    assign clr_req = wb_wr && wb_adr_i == REG_REC_CTRL && wb_dat_i[0];

    assign en_eff = enable_q[19:0] | HW_FIXED;

    // Flash, store and gross loop current faults stick until restart; restart re-samples the fault
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_q <= 3'h0;
        end else begin
            if (in_s2_q[19-10]) latch_q[0] <= 1'b1;
            if (in_s2_q[19-8])  latch_q[1] <= 1'b1;
            if (in_s2_q[19-6])  latch_q[2] <= 1'b1;
        end
    end

    // Clock validity flag
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            time_approx_q <= 1'b0;
        end else if (in_s2_q[7]) begin
            time_approx_q <= 1'b1;
        end else if (in_s2_q[6]) begin
            time_approx_q <= 1'b0;
        end
    end

    assign pdiff = (pressure_meas > pressure_setp) ? pressure_meas - pressure_setp
                                                   : pressure_setp - pressure_meas;

    // Record window offset, so entry 0 sits at the window base
    assign rec_off = wb_adr_i - REG_REC_BASE;

    always_comb begin
        cond            = 20'h0_0000;
        cond[A_FLASH]   = latch_q[0];
        cond[A_DRVCUR]  = in_s2_q[19-9];
        cond[A_CNVM]    = latch_q[1];
        cond[A_SENSOR]  = in_s2_q[19-7];
        cond[A_LOOP]    = latch_q[2];
        cond[A_REC_NE]  = rec_ne_q;
        cond[A_CAL]     = in_s2_q[19-4];
        cond[A_DIAG]    = in_s2_q[19-3];
        cond[A_AUTOCAL] = in_s2_q[19-5];
        cond[A_CYCHI]   = cyc_cnt_q > cyc_pt_q;
        cond[A_TIME]    = time_approx_q;
        cond[A_REC_FUL] = rec_full_q;
        cond[A_DDATA]   = in_s2_q[19-2];
        cond[A_PDEV]    = in_s2_q[8] && ({22'h0, pdiff} > pdev_q);
        cond[A_SATHI]   = in_s2_q[19-1];
        cond[A_SATLO]   = in_s2_q[19];
        cond[A_DRVSIG]  = drv_alert;
    end

    iam_drive_check u_drive (
        .clk            (clk),
        .rst_n          (rst_n),
        .drive          (drive_sig),
        .travel         (travel),
        .open_unpowered (open_unpowered_q),
        .enable         (en_eff[A_DRVSIG]),
        .alert_q        (drv_alert)
    );

    // Active alert set, gated by enables
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            active_q <= 20'h0_0000;
            prev_q   <= 20'h0_0000;
        end else begin
            active_q <= cond & en_eff;
            prev_q   <= active_q;
        end
    end

    // Record-state alerts are not logged themselves to avoid self-triggering
    assign rise = active_q & ~prev_q &
                  ~(20'h0_0001 << A_REC_NE) & ~(20'h0_0001 << A_REC_FUL);

    // Alert record: one entry per cycle in which any alert other than the record-state alerts rises, until the record is full
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rec_cnt_q  <= 5'h00;
            rec_full_q <= 1'b0;
            rec_ne_q   <= 1'b0;
        end else if (clr_req) begin
            rec_cnt_q  <= 5'h00;
            rec_full_q <= 1'b0;
            rec_ne_q   <= 1'b0;
        end else if (rise != 20'h0_0000 && rec_cnt_q < REC_DEPTH_V) begin
            rec_cnt_q  <= rec_cnt_q + 5'h01;
            rec_ne_q   <= 1'b1;
            rec_full_q <= (rec_cnt_q + 5'h01) == REC_DEPTH_V;
        end
    end

    // Simultaneous rises share one entry holding all bits that rose
    always_ff @(posedge clk) begin
        if (rise != 20'h0_0000 && rec_cnt_q < REC_DEPTH_V && !clr_req) begin
            rec_mem[rec_cnt_q] <= rise;
        end
    end

    // Cycle counter with deadband around the travel reference
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cyc_cnt_q <= 32'h0000_0000;
            ref_q     <= 10'h000;
            ext_q     <= 10'h000;
            dir_up_q  <= 1'b1;
        end else if (wb_wr && wb_adr_i == REG_CYC_CNT) begin
            cyc_cnt_q <= wb_dat_i;
        end else if (dir_up_q) begin
            if (travel > ext_q) begin
                ext_q <= travel;
            end else if ({22'h0, ext_q - travel} > dband_q &&
                         {22'h0, ext_q - ref_q} > dband_q) begin
                cyc_cnt_q <= cyc_cnt_q + 32'h0000_0001;
                ref_q     <= ext_q;
                ext_q     <= travel;
                dir_up_q  <= 1'b0;
            end
        end else begin
            if (travel < ext_q) begin
                ext_q <= travel;
            end else if ({22'h0, travel - ext_q} > dband_q &&
                         {22'h0, ref_q - ext_q} > dband_q) begin
                cyc_cnt_q <= cyc_cnt_q + 32'h0000_0001;
                ref_q     <= ext_q;
                ext_q     <= travel;
                dir_up_q  <= 1'b1;
            end
        end
    end

    // Configuration registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_q         <= ENABLE_RST;
            cyc_pt_q         <= CYC_PT_RST;
            dband_q          <= DBAND_RST;
            pdev_q           <= PDEV_RST;
            open_unpowered_q <= 1'b0;
        end else if (wb_wr) begin
            case (wb_adr_i)
                REG_ENABLE: enable_q         <= wb_dat_i;
                REG_CYC_PT: cyc_pt_q         <= wb_dat_i;
                REG_DBAND:  dband_q          <= wb_dat_i;
                REG_PDEV:   pdev_q           <= wb_dat_i;
                REG_CFG:    open_unpowered_q <= wb_dat_i[0];
                default:    ;
            endcase
        end
    end

    // Wishbone slave: ack one cycle after the strobe, unmapped reads zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h0000_0000;
            if (wb_req && !wb_we_i) begin
                case (wb_adr_i)
                    REG_ENABLE:   wb_dat_o <= {12'h000, en_eff};
                    REG_ACTIVE:   wb_dat_o <= {12'h000, active_q};
                    REG_REC_STAT: wb_dat_o <= {25'h0, rec_cnt_q, rec_full_q, rec_ne_q};
                    REG_CYC_CNT:  wb_dat_o <= cyc_cnt_q;
                    REG_CYC_PT:   wb_dat_o <= cyc_pt_q;
                    REG_DBAND:    wb_dat_o <= dband_q;
                    REG_PDEV:     wb_dat_o <= pdev_q;
                    REG_CFG:      wb_dat_o <= {31'h0, open_unpowered_q};
                    default: begin
                        if (wb_adr_i >= REG_REC_BASE &&
                            wb_adr_i < REG_REC_BASE + 8'(REC_DEPTH * 4) &&
                            rec_off[6:2] < rec_cnt_q) begin
                            wb_dat_o <= {12'h000, rec_mem[rec_off[6:2]]};
                        end
                    end
                endcase
            end
        end
    end

    // Additional status reply to the host command
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid_q  <= 1'b0;
            rsp_status_q <= 20'h0_0000;
        end else begin
            rsp_valid_q <= cmd_valid && cmd_num == CMD_ADD_STAT;
            if (cmd_valid && cmd_num == CMD_ADD_STAT) begin
                rsp_status_q <= active_q;
            end
        end
    end
endmodule : iam_monitor

// ==== pkg/iam_pkg.sv ====
// Constants, register map and field layout of the instrument alert monitor
package iam_pkg;
    localparam int          ALERT_N       = 20;
    localparam int          REC_DEPTH     = 20;
    localparam logic [4:0]  REC_DEPTH_V   = 5'h14;
    localparam int          CLK_HZ        = 40_000_000;
    localparam int          DRV_TIME_S    = 20;
    localparam logic [31:0] DRV_CYC       = 32'(DRV_TIME_S * CLK_HZ);
    localparam logic [7:0]  CMD_ADD_STAT  = 8'h30;
    localparam logic [9:0]  PCT_10        = 10'h064;
    localparam logic [9:0]  PCT_90        = 10'h384;
    localparam logic [9:0]  PCT_3         = 10'h01e;
    localparam logic [9:0]  PCT_97        = 10'h3ca;
    // Byte offsets of the Wishbone register words
    localparam logic [7:0]  REG_ENABLE    = 8'h00;
    localparam logic [7:0]  REG_ACTIVE    = 8'h04;
    localparam logic [7:0]  REG_REC_CTRL  = 8'h08;
    localparam logic [7:0]  REG_REC_STAT  = 8'h0c;
    localparam logic [7:0]  REG_CYC_CNT   = 8'h10;
    localparam logic [7:0]  REG_CYC_PT    = 8'h14;
    localparam logic [7:0]  REG_DBAND     = 8'h18;
    localparam logic [7:0]  REG_PDEV      = 8'h1c;
    localparam logic [7:0]  REG_CFG       = 8'h20;
    localparam logic [7:0]  REG_REC_BASE  = 8'h40;
    localparam logic [31:0] ENABLE_RST    = 32'h0000_0000;
    localparam logic [31:0] CYC_PT_RST    = 32'h0000_ffff;
    localparam logic [31:0] DBAND_RST     = 32'h0000_0064;
    localparam logic [31:0] PDEV_RST      = 32'h0000_0032;
    // Alert bit positions
    localparam int A_FLASH   = 0;
    localparam int A_DRVCUR  = 1;
    localparam int A_CNVM    = 2;
    localparam int A_SENSOR  = 3;
    localparam int A_LOOP    = 4;
    localparam int A_REC_NE  = 5;
    localparam int A_CAL     = 6;
    localparam int A_DIAG    = 7;
    localparam int A_AUTOCAL = 8;
    localparam int A_CYCHI   = 9;
    localparam int A_TIME    = 10;
    localparam int A_REC_FUL = 11;
    localparam int A_DDATA   = 12;
    localparam int A_PDEV    = 13;
    localparam int A_SATHI   = 14;
    localparam int A_SATLO   = 15;
    localparam int A_DRVSIG  = 16;
    localparam logic [19:0] HW_FIXED  = 20'h0_001f;
endpackage : iam_pkg
